// >>> hdl/fwiv_irq_vector.sv
// FIFO and waveform interrupt collector with fixed priority and autovector byte
// Function
// R1 - Fourteen FIFO and waveform event sources share one processor interrupt line.
// R2 - Endpoint 2/4/6/8 programmable flags: priorities 1-4, vectors 0x80-0x8C.
// R3 - Endpoint 2/4/6/8 empty flags: priorities 5-8, vectors 0x90-0x9C.
// R4 - Endpoint 2/4/6/8 full flags: priorities 9-12, vectors 0xA0-0xAC.
// R5 - Waveform done priority 13 vector 0xB0; waveform event priority 14 vector 0xB4.
// R6 - With autovector enabled, read of 0x0055 returns the winning vector byte.
// R7 - Processor keeps the jump-table page byte at 0x0054; the vector byte selects one of fourteen.
// R8 - Processor pushes its PC then fetches a jump instruction at 0x0053.
// R9 - Request stays high while enabled sources pend; winner recomputed as they clear.
//
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none

module fwiv_irq_vector
(
    input wire logic clk,
    input wire logic rstn,
    // Event sources, levels from same-clock FIFO and waveform logic
    input wire logic ep_two_prog_flag_event,
    input wire logic ep_four_prog_flag_event,
    input wire logic ep_six_prog_flag_event,
    input wire logic ep_eight_prog_flag_event,
    input wire logic ep_two_empty_event,
    input wire logic ep_four_empty_event,
    input wire logic ep_six_empty_event,
    input wire logic ep_eight_empty_event,
    input wire logic ep_two_full_event,
    input wire logic ep_four_full_event,
    input wire logic ep_six_full_event,
    input wire logic ep_eight_full_event,
    input wire logic waveform_done_event,
    input wire logic waveform_event,
    // Processor interrupt entry side
    input wire logic cpu_rd_req,
    input wire logic [15:0] cpu_rd_addr,
    input wire logic [7:0] cpu_mem_data,
    output logic [7:0] cpu_rd_data,
    output logic cpu_rd_valid,
    output logic fifo_event_irq,
    output logic [7:0] fifo_event_vector_byte,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);

    // ********************************************************
    // Priority encoding
    // ********************************************************
    // Index 0 is priority 1; vector rises by four per step
    function automatic logic [7:0] fwiv_vector(input logic [13:0] pend);
        logic [7:0] v;
        v = fwiv_pkg::VEC_IDLE;
        for (int i = fwiv_pkg::SRC_COUNT - 1; i >= 0; i--)
        begin
            if (pend[i])
            begin
                v = fwiv_pkg::VEC_BASE + 8'(4 * i);
            end
        end
        return v;
    endfunction : fwiv_vector

    // ********************************************************
    // Event capture
    // ********************************************************
    logic [13:0] src_vec;
    logic [13:0] src_prev_reg;
    logic [13:0] src_rise;
    logic [13:0] status_reg;
    logic [13:0] status_next;
    logic [13:0] mask_reg;
    logic aven_reg;
    logic [13:0] pend;
    logic [13:0] w1c;

    assign src_vec = {waveform_event, waveform_done_event,
                      ep_eight_full_event, ep_six_full_event,
                      ep_four_full_event, ep_two_full_event,
                      ep_eight_empty_event, ep_six_empty_event,
                      ep_four_empty_event, ep_two_empty_event,
                      ep_eight_prog_flag_event, ep_six_prog_flag_event,
                      ep_four_prog_flag_event, ep_two_prog_flag_event};
    assign src_rise = src_vec & ~src_prev_reg;
    assign pend = status_reg & mask_reg;

    // Tracks the sources in reset too, so a level already high is no event
    always_ff @(posedge clk)
    begin
        src_prev_reg <= src_vec;
    end

    // Set wins over a write-one-to-clear in the same cycle
    assign status_next = (status_reg & ~w1c) | src_rise; // [R1]

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            status_reg <= fwiv_pkg::RST_STATUS;
        end
        else
        begin
            status_reg <= status_next;
        end
    end

    // ********************************************************
    // Shared request and vector
    // ********************************************************
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            fifo_event_irq <= 1'b0;
            fifo_event_vector_byte <= fwiv_pkg::VEC_IDLE;
        end
        else
        begin
            fifo_event_irq <= |pend; // [R1] [R9]
            fifo_event_vector_byte <= fwiv_vector(pend); // [R2] [R3] [R4] [R5] [R9]
        end
    end

    // Substitution of the low jump-table byte at interrupt entry
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            cpu_rd_data <= 8'h00;
            cpu_rd_valid <= 1'b0;
        end
        else
        begin
            cpu_rd_valid <= cpu_rd_req;
            if (cpu_rd_req)
            begin
                if (aven_reg && cpu_rd_addr == fwiv_pkg::ADDR_VECTOR_BYTE)
                begin
                    cpu_rd_data <= fifo_event_vector_byte; // [R6]
                end
                else
                begin
                    cpu_rd_data <= cpu_mem_data;
                end
            end
        end
    end

    // ********************************************************
    // AHB-Lite register slave
    // ********************************************************
    // Zero wait states; read data is captured at the address phase
    logic addr_ok;
    logic wr_pend_reg;
    logic [7:0] wr_ofs_reg;
    logic [31:0] rd_word;

    assign addr_ok = hsel && hready && (htrans == fwiv_pkg::HTRANS_NONSEQ || htrans == 2'h3);
    assign w1c = (wr_pend_reg && wr_ofs_reg == fwiv_pkg::OFS_STATUS) ? hwdata[13:0] : 14'h0000;

    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (haddr[7:0])
            fwiv_pkg::OFS_STATUS: rd_word = {18'h0_0000, status_reg};
            fwiv_pkg::OFS_MASK: rd_word = {18'h0_0000, mask_reg};
            fwiv_pkg::OFS_SETUP: rd_word = {31'h0000_0000, aven_reg};
            fwiv_pkg::OFS_VECTOR: rd_word = {23'h00_0000, fifo_event_irq, fifo_event_vector_byte};
            fwiv_pkg::OFS_RAW: rd_word = {18'h0_0000, src_vec};
            default: rd_word = 32'h0000_0000;
        endcase
        if (haddr[31:8] != 24'h00_0000)
        begin
            rd_word = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            wr_pend_reg <= 1'b0;
            wr_ofs_reg <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= fwiv_pkg::HRESP_OKAY;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= fwiv_pkg::HRESP_OKAY;
            wr_pend_reg <= addr_ok && hwrite && haddr[31:8] == 24'h00_0000;
            if (addr_ok)
            begin
                wr_ofs_reg <= haddr[7:0];
                hrdata <= hwrite ? 32'h0000_0000 : rd_word;
            end
        end
    end

    // Mask and autovector enable steer the request and substitution
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            mask_reg <= fwiv_pkg::RST_MASK;
            aven_reg <= fwiv_pkg::RST_AVEN;
        end
        else if (wr_pend_reg)
        begin
            if (wr_ofs_reg == fwiv_pkg::OFS_MASK)
            begin
                mask_reg <= hwdata[13:0];
            end
            if (wr_ofs_reg == fwiv_pkg::OFS_SETUP)
            begin
                aven_reg <= hwdata[fwiv_pkg::SETUP_AVEN_BIT];
            end
        end
    end

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    property p_event_sets_status;
        (src_rise != 14'h0000) |=> ((status_reg & $past(src_rise)) == $past(src_rise));
    endproperty
    a_event_sets_status: assert property (p_event_sets_status) // [R1]
        else $error("Rising source did not set its status bit");

    property p_irq_level;
        (pend != 14'h0000) |=> fifo_event_irq;
    endproperty
    a_irq_level: assert property (p_irq_level) // [R9]
        else $error("Request low while enabled source pending");

    property p_irq_drop;
        (pend == 14'h0000) |=> !fifo_event_irq;
    endproperty
    a_irq_drop: assert property (p_irq_drop) // [R9]
        else $error("Request high with nothing pending");

    property p_prog_vectors;
        (pend[0]) |=> fifo_event_vector_byte == 8'h80;
    endproperty
    a_prog_vectors: assert property (p_prog_vectors) // [R2]
        else $error("Top priority source did not give vector 0x80");

    property p_prog_last;
        (pend[2:0] == 3'h0 && pend[3]) |=> fifo_event_vector_byte == 8'h8C;
    endproperty
    a_prog_last: assert property (p_prog_last) // [R2]
        else $error("Fourth priority source did not give vector 0x8C");

    property p_empty_vectors;
        (pend[3:0] == 4'h0 && pend[4]) |=> fifo_event_vector_byte == 8'h90;
    endproperty
    a_empty_vectors: assert property (p_empty_vectors) // [R3]
        else $error("First empty flag did not give vector 0x90");

    property p_full_vectors;
        (pend[10:0] == 11'h000 && pend[11]) |=> fifo_event_vector_byte == 8'hAC;
    endproperty
    a_full_vectors: assert property (p_full_vectors) // [R4]
        else $error("Last full flag did not give vector 0xAC");

    property p_wave_vectors;
        (pend == 14'h2000) ##1 (pend == 14'h2000) |-> fifo_event_vector_byte == 8'hB4;
    endproperty
    a_wave_vectors: assert property (p_wave_vectors) // [R5]
        else $error("Lowest priority source did not give vector 0xB4");

    property p_done_vector;
        (pend[11:0] == 12'h000 && pend[12]) |=> fifo_event_vector_byte == 8'hB0;
    endproperty
    a_done_vector: assert property (p_done_vector) // [R5]
        else $error("Waveform done did not give vector 0xB0");

    property p_autovector;
        (cpu_rd_req && aven_reg && cpu_rd_addr == 16'h0055)
            |=> cpu_rd_valid && cpu_rd_data == $past(fifo_event_vector_byte);
    endproperty
    a_autovector: assert property (p_autovector) // [R6]
        else $error("Vector byte not substituted at 0x0055");

    property p_no_autovector;
        (cpu_rd_req && !aven_reg) |=> cpu_rd_data == $past(cpu_mem_data);
    endproperty
    a_no_autovector: assert property (p_no_autovector) // [R6]
        else $error("Memory byte altered with autovector off");

    c_autovector_read: cover property (cpu_rd_req && aven_reg && cpu_rd_addr == 16'h0055);
    c_two_pending: cover property ($countones(pend) >= 2 ##1 $countones(pend) == 1);
    c_w1c_race: cover property ((w1c & src_rise) != 14'h0000);

endmodule : fwiv_irq_vector

`default_nettype wire

// >>> hdl/fwiv_pkg.sv
// Constants shared by the FIFO and waveform interrupt vectoring block
package fwiv_pkg;

    // ********************************************************
    // Sources and vectors
    // ********************************************************
    localparam int SRC_COUNT = 14;
    localparam logic [7:0] VEC_BASE = 8'h80;
    localparam logic [7:0] VEC_IDLE = 8'h00;

    // Processor addresses used at interrupt entry
    localparam logic [15:0] ADDR_JUMP_INSN = 16'h0053;
    localparam logic [15:0] ADDR_PAGE_BYTE = 16'h0054;
    localparam logic [15:0] ADDR_VECTOR_BYTE = 16'h0055;

    // ********************************************************
    // Register map, byte offsets
    // ********************************************************
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_SETUP = 8'h08;
    localparam logic [7:0] OFS_VECTOR = 8'h0C;
    localparam logic [7:0] OFS_RAW = 8'h10;

    // Field positions
    localparam int SETUP_AVEN_BIT = 0;
    localparam int VECTOR_ACTIVE_BIT = 8;

    // Values after reset
    localparam logic [13:0] RST_STATUS = 14'h0000;
    localparam logic [13:0] RST_MASK = 14'h0000;
    localparam logic RST_AVEN = 1'b0;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

endpackage : fwiv_pkg

// >>> verif/fwiv_cpu_model.sv
// Behavioural processor interrupt entry model facing the vectoring block
`timescale 1ns/100ps
`default_nettype none

module fwiv_cpu_model
#(
    parameter logic [7:0] PAGE_BYTE = 8'h1C,
    parameter logic [7:0] JUMP_OPCODE = 8'h02,
    parameter logic [7:0] PLAIN_VECTOR = 8'h5A
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic irq,
    input wire logic enter,
    input wire logic [3:0] gap,
    output logic cpu_rd_req,
    output logic [15:0] cpu_rd_addr,
    output logic [7:0] cpu_mem_data,
    input wire logic [7:0] cpu_rd_data,
    input wire logic cpu_rd_valid,
    output logic [15:0] handler_addr,
    output logic entry_done
);
    logic [7:0] stack_ptr;
    logic [7:0] fetched [3];

    function automatic logic [7:0] mem_byte(input logic [1:0] k);
        case (k)
            2'h0: mem_byte = JUMP_OPCODE;
            2'h1: mem_byte = PAGE_BYTE;
            default: mem_byte = PLAIN_VECTOR;
        endcase
    endfunction : mem_byte

    initial
    begin
        cpu_rd_req = 1'b0;
        cpu_rd_addr = 16'h0000;
        cpu_mem_data = 8'hA5;
        handler_addr = 16'h0000;
        entry_done = 1'b0;
        stack_ptr = 8'h07;
    end

    // ********************************************************
    // Interrupt entry: push, then fetch opcode, page and vector
    // ********************************************************
    always @(posedge clk)
    begin
        if (rstn && enter && irq)
        begin
            stack_ptr <= stack_ptr + 8'h02;
            for (int k = 0; k < 3; k++)
            begin
                repeat (gap) @(posedge clk);
                cpu_rd_req <= 1'b1;
                cpu_rd_addr <= fwiv_pkg::ADDR_JUMP_INSN + 16'(k);
                cpu_mem_data <= mem_byte(2'(k));
                @(posedge clk);
                cpu_rd_req <= 1'b0;
                // Released bus shows the inverse, never a stale copy
                cpu_mem_data <= ~cpu_mem_data;
                cpu_rd_addr <= ~cpu_rd_addr;
                @(posedge clk);
                fetched[k] = cpu_rd_valid ? cpu_rd_data : 8'hxx;
            end
            handler_addr <= {fetched[1], fetched[2]};
            entry_done <= 1'b1;
            @(posedge clk);
            entry_done <= 1'b0;
            // Extra edge lets the bench drop its entry request first
            @(posedge clk);
        end
    end
endmodule : fwiv_cpu_model
`default_nettype wire

// >>> verif/fwiv_irq_vector_tb_top.sv
// Self-checking bench for the FIFO and waveform interrupt vectoring block
`timescale 1ns/100ps
`default_nettype none

module fwiv_irq_vector_tb_top;
    localparam logic [7:0] PAGE = 8'h1C;
    localparam logic [7:0] PLAIN = 8'h5A;
    // Vector bytes in priority order, kept apart from the design's arithmetic
    localparam logic [7:0] VEC_TABLE [14] = '{8'h80, 8'h84, 8'h88, 8'h8C, 8'h90, 8'h94, 8'h98,
        8'h9C, 8'hA0, 8'hA4, 8'hA8, 8'hAC, 8'hB0, 8'hB4};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [13:0] src = 14'h0000;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic enter = 1'b0;
    logic [3:0] gap = 4'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, cpu_rd_req, cpu_rd_valid, irq, done;
    logic [15:0] cpu_rd_addr, handler;
    logic [7:0] cpu_mem_data, cpu_rd_data, vbyte, vec;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    fwiv_irq_vector u_fwiv_irq_vector (.clk(clk), .rstn(rstn),
        .ep_two_prog_flag_event(src[0]), .ep_four_prog_flag_event(src[1]),
        .ep_six_prog_flag_event(src[2]), .ep_eight_prog_flag_event(src[3]),
        .ep_two_empty_event(src[4]), .ep_four_empty_event(src[5]),
        .ep_six_empty_event(src[6]), .ep_eight_empty_event(src[7]),
        .ep_two_full_event(src[8]), .ep_four_full_event(src[9]),
        .ep_six_full_event(src[10]), .ep_eight_full_event(src[11]),
        .waveform_done_event(src[12]), .waveform_event(src[13]),
        .cpu_rd_req(cpu_rd_req), .cpu_rd_addr(cpu_rd_addr), .cpu_mem_data(cpu_mem_data),
        .cpu_rd_data(cpu_rd_data), .cpu_rd_valid(cpu_rd_valid), .fifo_event_irq(irq),
        .fifo_event_vector_byte(vbyte), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

    fwiv_cpu_model #(.PAGE_BYTE(PAGE), .PLAIN_VECTOR(PLAIN)) u_fwiv_cpu_model (
        .clk(clk), .rstn(rstn), .irq(irq), .enter(enter), .gap(gap),
        .cpu_rd_req(cpu_rd_req), .cpu_rd_addr(cpu_rd_addr), .cpu_mem_data(cpu_mem_data),
        .cpu_rd_data(cpu_rd_data), .cpu_rd_valid(cpu_rd_valid),
        .handler_addr(handler), .entry_done(done));

    // ********************************************************
    // Checks and bus tasks
    // ********************************************************
    task automatic end_of_test();
        if (n_mismatch == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk16

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic ahb(input logic wr_en, input logic [7:0] ofs, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, ofs};
        htrans <= fwiv_pkg::HTRANS_NONSEQ;
        hwrite <= wr_en;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : ahb

    task automatic rdc(input logic [7:0] ofs, input logic [31:0] exp);
        ahb(1'b0, ofs, 32'h0000_0000);
        chk32(rd, exp);
        chk32({31'h0000_0000, hresp}, 32'h0000_0000);
    endtask : rdc

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        ahb(1'b1, ofs, d);
    endtask : wr

    task automatic entry();
        enter <= 1'b1;
        for (int k = 0; k < 100 && done !== 1'b1; k++) @(posedge clk);
        enter <= 1'b0;
    endtask : entry

    // Whole run needs about 700 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ********************************************************
    // Scenarios
    // ********************************************************
    initial
    begin
        tick(8);
        rstn <= 1'b1;
        tick(1);
        rdc(fwiv_pkg::OFS_STATUS, 32'h0000_0000);
        rdc(fwiv_pkg::OFS_SETUP, 32'h0000_0000);
        rdc(8'h14, 32'h0000_0000);
        wr(fwiv_pkg::OFS_VECTOR, 32'hFFFF_FFFF);
        rdc(fwiv_pkg::OFS_VECTOR, 32'h0000_0000);
        wr(fwiv_pkg::OFS_MASK, 32'hFFFF_FFFF);
        rdc(fwiv_pkg::OFS_MASK, 32'h0000_3FFF);
        wr(fwiv_pkg::OFS_SETUP, 32'h0000_0001);
        // One source at a time, each with its own entry speed
        for (int i = 0; i < 14; i++)
        begin
            vec = VEC_TABLE[i];
            src <= 14'(1 << i);
            gap <= 4'(i);
            tick(3);
            rdc(fwiv_pkg::OFS_VECTOR, {23'h00_0000, 1'b1, vec});
            chk32({24'h00_0000, vbyte}, {24'h00_0000, vec});
            chk32({31'h0000_0000, irq}, 32'h0000_0001);
            entry();
            chk16(handler, {PAGE, vec});
            src <= 14'h0000;
            wr(fwiv_pkg::OFS_STATUS, 32'(1) << i);
            tick(1);
            rdc(fwiv_pkg::OFS_VECTOR, 32'h0000_0000);
        end
        // All pending together, cleared from the top of the ranking down
        src <= 14'h3FFF;
        tick(3);
        for (int i = 0; i < 14; i++)
        begin
            vec = VEC_TABLE[i];
            rdc(fwiv_pkg::OFS_VECTOR, {23'h00_0000, 1'b1, vec});
            chk32({31'h0000_0000, irq}, 32'h0000_0001);
            wr(fwiv_pkg::OFS_STATUS, 32'(1) << i);
            tick(1);
        end
        // Request register drops one edge after the last clear lands
        tick(1);
        chk32({31'h0000_0000, irq}, 32'h0000_0000);
        src <= 14'h0000;
        wr(fwiv_pkg::OFS_MASK, 32'h0000_0000);
        src <= 14'h3FFF;
        tick(3);
        rdc(fwiv_pkg::OFS_STATUS, 32'h0000_3FFF);
        chk32({31'h0000_0000, irq}, 32'h0000_0000);
        wr(fwiv_pkg::OFS_MASK, 32'h0000_2000);
        tick(2);
        rdc(fwiv_pkg::OFS_VECTOR, 32'h0000_01B4);
        wr(fwiv_pkg::OFS_STATUS, 32'h0000_3FFF);
        tick(2);
        chk32({31'h0000_0000, irq}, 32'h0000_0000);
        // Autovector off: the plain memory byte reaches the processor
        wr(fwiv_pkg::OFS_SETUP, 32'h0000_0000);
        wr(fwiv_pkg::OFS_MASK, 32'h0000_3FFF);
        src <= 14'h0000;
        tick(2);
        src <= 14'h0001;
        tick(3);
        entry();
        chk16(handler, {PAGE, PLAIN});
        end_of_test();
    end
endmodule : fwiv_irq_vector_tb_top
`default_nettype wire
